// File: src/rtui_irq_core.sv
// rtc countdown, periodic update and alarm interrupt logic
`timescale 1ns/1ps
`default_nettype none
module rtui_irq_core #(
    parameter int unsigned TICK_CYC = rtui_pkg::TICK_CYC,
    parameter int unsigned START_DLY_CYC = rtui_pkg::START_DLY_CYC,
    parameter int unsigned CD_HOLD_FAST_CYC = rtui_pkg::CD_HOLD_FAST_CYC,
    parameter int unsigned CD_HOLD_SLOW_CYC = rtui_pkg::CD_HOLD_SLOW_CYC,
    parameter int unsigned UPD_HOLD_SEC_CYC = rtui_pkg::UPD_HOLD_SEC_CYC,
    parameter int unsigned UPD_HOLD_MIN_CYC = rtui_pkg::UPD_HOLD_MIN_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register port
    input wire logic [4:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // external event input
    input wire logic ext_event_pin,
    // open drain interrupt
    output logic irq_n_out,
    output logic irq_n_oe,
    // clock output gating
    output logic update_pulse,
    output logic alarm_pulse,
    output logic clk_out_req
);
    // time base
    logic [31:0] base_cnt;
    logic [11:0] sub_cnt;
    logic [5:0] sec;
    logic [5:0] minute;
    logic [4:0] hour;
    logic [4:0] date;
    // configuration
    logic [7:0] alm_min;
    logic [7:0] alm_hour;
    logic [7:0] alm_date;
    logic [11:0] preset;
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    // countdown
    rtui_pkg::rtui_cd_state_t cd_state;
    rtui_pkg::rtui_cd_state_t next_cd_state;
    logic [12:0] cd_count;
    logic [12:0] next_cd_count;
    logic [31:0] dly_cnt;
    // flags and pulses
    logic countdown_flag;
    logic update_flag;
    logic alarm_flag;
    logic cd_low;
    logic upd_low;
    logic [31:0] cd_hold;
    logic [31:0] upd_hold;
    logic min_tick_d;
    logic ext_prev;

    // field decode
    wire logic [1:0] tick_rate_sel = ctrl1[1:0];
    wire logic countdown_run = ctrl1[rtui_pkg::C1_RUN];
    wire logic update_period_sel = ctrl1[rtui_pkg::C1_UPD_SEL];
    wire logic clock_stop = ctrl1[rtui_pkg::C1_STOP];
    wire logic countdown_irq_en = ctrl2[rtui_pkg::C2_CD_IE];
    wire logic update_irq_en = ctrl2[rtui_pkg::C2_UPD_IE];
    wire logic alarm_irq_en = ctrl2[rtui_pkg::C2_ALM_IE];
    wire logic update_clk_gate_en = ctrl2[rtui_pkg::C2_UPD_GATE];
    wire logic alarm_clk_gate_en = ctrl2[rtui_pkg::C2_ALM_GATE];
    wire logic event_sync_en = ctrl2[rtui_pkg::C2_SYNC];
    wire logic minute_match_off = alm_min[rtui_pkg::ALM_OFF];
    wire logic hour_match_off = alm_hour[rtui_pkg::ALM_OFF];
    wire logic date_match_off = alm_date[rtui_pkg::ALM_OFF];

    // write decode
    // strobe and address are arguments so continuous users re-evaluate on them
    function automatic logic wr_hit(input logic we, input logic [4:0] ad, input logic [4:0] a);
        wr_hit = we && (ad == a);
    endfunction : wr_hit

    wire logic wr_sec = wr_hit(reg_wr, reg_addr, rtui_pkg::REG_SECONDS);
    wire logic wr_min = wr_hit(reg_wr, reg_addr, rtui_pkg::REG_MINUTES);
    wire logic wr_hour = wr_hit(reg_wr, reg_addr, rtui_pkg::REG_HOURS);
    wire logic wr_date = wr_hit(reg_wr, reg_addr, rtui_pkg::REG_DATE);
    wire logic wr_status = wr_hit(reg_wr, reg_addr, rtui_pkg::REG_STATUS);

    // divider restart on seconds write or synchronising event
    wire logic ext_rise = ext_event_pin && !ext_prev;
    wire logic div_restart = wr_sec || (event_sync_en && ext_rise);
    wire logic base_tick = !clock_stop && (base_cnt == TICK_CYC - 1);
    wire logic tick_64 = base_tick && (sub_cnt[5:0] == 6'h3f);
    wire logic sec_tick = base_tick && (sub_cnt == 12'hfff);
    wire logic min_tick = sec_tick && (sec == rtui_pkg::SEC_MAX);
    wire logic hour_tick = min_tick && (minute == rtui_pkg::SEC_MAX);
    wire logic day_tick = hour_tick && (hour == rtui_pkg::HOUR_MAX);

    // selected countdown tick
    logic cd_tick;
    always_comb begin
        case (tick_rate_sel)
            rtui_pkg::TICK_4096: cd_tick = base_tick;
            rtui_pkg::TICK_64: cd_tick = tick_64;
            rtui_pkg::TICK_1: cd_tick = sec_tick;
            rtui_pkg::TICK_MIN: cd_tick = min_tick;
            default: cd_tick = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst || div_restart || clock_stop || base_tick) begin
            base_cnt <= 32'h0;
        end else begin
            base_cnt <= base_cnt + 32'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || div_restart || clock_stop) begin
            sub_cnt <= 12'h000;
        end else if (base_tick) begin
            sub_cnt <= sub_cnt + 12'h001;
        end
    end

    // time counters, a write wins over the increment
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sec <= 6'h00;
        end else if (wr_sec) begin
            sec <= reg_wdata[5:0];
        end else if (min_tick) begin
            sec <= 6'h00;
        end else if (sec_tick) begin
            sec <= sec + 6'h01;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            minute <= 6'h00;
        end else if (wr_min) begin
            minute <= reg_wdata[5:0];
        end else if (hour_tick) begin
            minute <= 6'h00;
        end else if (min_tick) begin
            minute <= minute + 6'h01;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            hour <= 5'h00;
        end else if (wr_hour) begin
            hour <= reg_wdata[4:0];
        end else if (day_tick) begin
            hour <= 5'h00;
        end else if (hour_tick) begin
            hour <= hour + 5'h01;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            date <= rtui_pkg::DATE_RESET;
        end else if (wr_date) begin
            date <= reg_wdata[4:0];
        end else if (day_tick && date == rtui_pkg::DATE_MAX) begin
            date <= rtui_pkg::DATE_RESET;
        end else if (day_tick) begin
            date <= date + 5'h01;
        end
    end

    // configuration registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            alm_min <= 8'h00;
            alm_hour <= 8'h00;
            alm_date <= 8'h00;
            preset <= 12'h000;
            ctrl1 <= 8'h00;
            ctrl2 <= 8'h00;
            ext_prev <= 1'b0;
        end else begin
            ext_prev <= ext_event_pin;
            if (wr_hit(reg_wr, reg_addr, rtui_pkg::REG_ALM_MIN)) alm_min <= reg_wdata;
            if (wr_hit(reg_wr, reg_addr, rtui_pkg::REG_ALM_HOUR)) alm_hour <= reg_wdata;
            if (wr_hit(reg_wr, reg_addr, rtui_pkg::REG_ALM_DATE)) alm_date <= reg_wdata;
            if (wr_hit(reg_wr, reg_addr, rtui_pkg::REG_PRESET_LO)) preset[7:0] <= reg_wdata;
            if (wr_hit(reg_wr, reg_addr, rtui_pkg::REG_PRESET_HI)) preset[11:8] <= reg_wdata[3:0];
            if (wr_hit(reg_wr, reg_addr, rtui_pkg::REG_CTRL1)) ctrl1 <= reg_wdata;
            if (wr_hit(reg_wr, reg_addr, rtui_pkg::REG_CTRL2)) ctrl2 <= reg_wdata;
        end
    end

    // countdown state machine
    wire logic cd_start = countdown_run && (preset != 12'h000);
    wire logic dly_done = (dly_cnt == START_DLY_CYC - 1);
    wire logic cd_event = (cd_state == rtui_pkg::RTUI_CD_COUNT) && cd_tick && (cd_count == 13'h0001);

    always_comb begin
        next_cd_state = cd_state;
        next_cd_count = cd_count;
        case (cd_state)
            rtui_pkg::RTUI_CD_IDLE: begin
                if (cd_start) begin
                    // one spare tick keeps the first period between n and n+1
                    next_cd_count = {1'b0, preset} + 13'h0001;
                    if (tick_rate_sel == rtui_pkg::TICK_4096) begin
                        next_cd_state = rtui_pkg::RTUI_CD_DELAY;
                    end else begin
                        next_cd_state = rtui_pkg::RTUI_CD_COUNT;
                    end
                end
            end
            rtui_pkg::RTUI_CD_DELAY: begin
                if (dly_done) next_cd_state = rtui_pkg::RTUI_CD_COUNT;
            end
            rtui_pkg::RTUI_CD_COUNT: begin
                if (cd_event) begin
                    next_cd_count = {1'b0, preset};
                end else if (cd_tick) begin
                    next_cd_count = cd_count - 13'h0001;
                end
            end
            default: next_cd_state = rtui_pkg::RTUI_CD_IDLE;
        endcase
        if (!countdown_run) begin
            next_cd_state = rtui_pkg::RTUI_CD_IDLE;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cd_state <= rtui_pkg::RTUI_CD_IDLE;
            cd_count <= 13'h0000;
            dly_cnt <= 32'h0;
        end else begin
            cd_state <= next_cd_state;
            cd_count <= next_cd_count;
            dly_cnt <= (cd_state == rtui_pkg::RTUI_CD_DELAY) ? dly_cnt + 32'h1 : 32'h0;
        end
    end

    // update and alarm events
    wire logic upd_event = update_period_sel ? min_tick : sec_tick;
    wire logic upd_fire = upd_event && update_irq_en;

    function automatic logic alarm_match(input logic [7:0] mi, input logic [7:0] hr, input logic [7:0] dt,
                                         input logic [5:0] m, input logic [4:0] h, input logic [4:0] d);
        logic m_ok;
        logic h_ok;
        logic d_ok;
        m_ok = mi[7] || (mi[5:0] == m);
        h_ok = hr[7] || (hr[4:0] == h);
        d_ok = dt[7] || ((dt[4:0] == d) && (dt[4:0] != 5'h00));
        alarm_match = m_ok && h_ok && d_ok;
    endfunction : alarm_match

    // checked one cycle after the minute step, on the new time
    wire logic all_off = minute_match_off && hour_match_off && date_match_off;
    wire logic alm_event = min_tick_d && (all_off || alarm_match(alm_min, alm_hour, alm_date,
                                                                  minute, hour, date));

    // flags: hardware set wins over a software clear in the same cycle
    wire logic clr_cd = wr_status && !reg_wdata[rtui_pkg::ST_COUNTDOWN];
    wire logic clr_upd = wr_status && !reg_wdata[rtui_pkg::ST_UPDATE];
    wire logic clr_alm = wr_status && !reg_wdata[rtui_pkg::ST_ALARM];
    wire logic next_countdown_flag = cd_event || (countdown_flag && !clr_cd);
    wire logic next_update_flag = upd_fire || (update_flag && !clr_upd);
    wire logic next_alarm_flag = alm_event || (alarm_flag && !clr_alm);

    // pulse hold lengths
    wire logic [31:0] cd_hold_len = (tick_rate_sel == rtui_pkg::TICK_4096) ?
                                    32'(CD_HOLD_FAST_CYC) : 32'(CD_HOLD_SLOW_CYC);
    wire logic [31:0] upd_hold_len = update_period_sel ? 32'(UPD_HOLD_MIN_CYC) : 32'(UPD_HOLD_SEC_CYC);
    wire logic cd_hold_done = (cd_hold == cd_hold_len - 32'h1);
    wire logic upd_hold_done = (upd_hold == upd_hold_len - 32'h1);

    wire logic next_cd_low = (cd_event && countdown_irq_en) ||
                             (cd_low && !cd_hold_done && next_countdown_flag && countdown_irq_en);
    wire logic next_upd_low = upd_fire ||
                              (upd_low && !upd_hold_done && next_update_flag && update_irq_en);
    wire logic next_alm_low = next_alarm_flag && alarm_irq_en;
    wire logic next_irq_low = next_cd_low || next_upd_low || next_alm_low;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            countdown_flag <= 1'b0;
            update_flag <= 1'b0;
            alarm_flag <= 1'b0;
            min_tick_d <= 1'b0;
        end else begin
            countdown_flag <= next_countdown_flag;
            update_flag <= next_update_flag;
            alarm_flag <= next_alarm_flag;
            min_tick_d <= min_tick;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cd_low <= 1'b0;
            upd_low <= 1'b0;
            cd_hold <= 32'h0;
            upd_hold <= 32'h0;
        end else begin
            cd_low <= next_cd_low;
            upd_low <= next_upd_low;
            cd_hold <= (cd_event || !cd_low) ? 32'h0 : cd_hold + 32'h1;
            upd_hold <= (upd_fire || !upd_low) ? 32'h0 : upd_hold + 32'h1;
        end
    end

    // pin and gating outputs
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_n_out <= 1'b0;
            irq_n_oe <= 1'b0;
            update_pulse <= 1'b0;
            alarm_pulse <= 1'b0;
            clk_out_req <= 1'b0;
        end else begin
            irq_n_out <= 1'b0;
            irq_n_oe <= next_irq_low;
            update_pulse <= next_upd_low;
            alarm_pulse <= next_alm_low;
            clk_out_req <= (next_upd_low && update_clk_gate_en) || (next_alm_low && alarm_clk_gate_en);
        end
    end

    // read mux
    logic [7:0] rd_mux;
    always_comb begin
        case (reg_addr)
            rtui_pkg::REG_SECONDS: rd_mux = {2'h0, sec};
            rtui_pkg::REG_MINUTES: rd_mux = {2'h0, minute};
            rtui_pkg::REG_HOURS: rd_mux = {3'h0, hour};
            rtui_pkg::REG_DATE: rd_mux = {3'h0, date};
            rtui_pkg::REG_ALM_MIN: rd_mux = alm_min;
            rtui_pkg::REG_ALM_HOUR: rd_mux = alm_hour;
            rtui_pkg::REG_ALM_DATE: rd_mux = alm_date;
            rtui_pkg::REG_PRESET_LO: rd_mux = preset[7:0];
            rtui_pkg::REG_PRESET_HI: rd_mux = {4'h0, preset[11:8]};
            rtui_pkg::REG_STATUS: rd_mux = {5'h00, alarm_flag, update_flag, countdown_flag};
            rtui_pkg::REG_CTRL1: rd_mux = ctrl1;
            rtui_pkg::REG_CTRL2: rd_mux = ctrl2;
            rtui_pkg::REG_COUNT_LO: rd_mux = cd_count[7:0];
            rtui_pkg::REG_COUNT_HI: rd_mux = {3'h0, cd_count[12:8]};
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
        end
    end
endmodule : rtui_irq_core
`default_nettype wire

// File: pkg/rtui_pkg.sv
// constants of the rtc timer, update and alarm interrupt block
`default_nettype none
package rtui_pkg;
    // clock and time base
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned TICK_HZ = 4096;
    localparam int unsigned TICK_CYC = CLK_HZ / TICK_HZ;
    // first period offset for the fastest tick, least time
    localparam int unsigned START_DLY_NS = 61000;
    localparam int unsigned START_DLY_CYC = (START_DLY_NS * CLK_MHZ + 999) / 1000;
    // countdown pulse hold times
    localparam int unsigned CD_HOLD_FAST_NS = 122000;
    localparam int unsigned CD_HOLD_FAST_CYC = CD_HOLD_FAST_NS * CLK_MHZ / 1000;
    localparam int unsigned CD_HOLD_SLOW_NS = 7_813_000;
    localparam int unsigned CD_HOLD_SLOW_CYC = CD_HOLD_SLOW_NS * CLK_MHZ / 1000;
    // update pulse hold times
    localparam int unsigned UPD_HOLD_SEC_US = 500_000;
    localparam int unsigned UPD_HOLD_SEC_CYC = UPD_HOLD_SEC_US * CLK_MHZ;
    localparam int unsigned UPD_HOLD_MIN_US = 15_600;
    localparam int unsigned UPD_HOLD_MIN_CYC = UPD_HOLD_MIN_US * CLK_MHZ;
    // register offsets
    localparam logic [4:0] REG_SECONDS = 5'h00;
    localparam logic [4:0] REG_MINUTES = 5'h01;
    localparam logic [4:0] REG_HOURS = 5'h02;
    localparam logic [4:0] REG_DATE = 5'h03;
    localparam logic [4:0] REG_ALM_MIN = 5'h04;
    localparam logic [4:0] REG_ALM_HOUR = 5'h05;
    localparam logic [4:0] REG_ALM_DATE = 5'h06;
    localparam logic [4:0] REG_PRESET_LO = 5'h07;
    localparam logic [4:0] REG_PRESET_HI = 5'h08;
    localparam logic [4:0] REG_STATUS = 5'h09;
    localparam logic [4:0] REG_CTRL1 = 5'h0a;
    localparam logic [4:0] REG_CTRL2 = 5'h0b;
    localparam logic [4:0] REG_COUNT_LO = 5'h0c;
    localparam logic [4:0] REG_COUNT_HI = 5'h0d;
    // field positions
    localparam int unsigned ST_COUNTDOWN = 0;
    localparam int unsigned ST_UPDATE = 1;
    localparam int unsigned ST_ALARM = 2;
    localparam int unsigned C1_RUN = 2;
    localparam int unsigned C1_UPD_SEL = 4;
    localparam int unsigned C1_STOP = 7;
    localparam int unsigned C2_CD_IE = 0;
    localparam int unsigned C2_UPD_IE = 1;
    localparam int unsigned C2_ALM_IE = 2;
    localparam int unsigned C2_UPD_GATE = 3;
    localparam int unsigned C2_ALM_GATE = 4;
    localparam int unsigned C2_SYNC = 5;
    localparam int unsigned ALM_OFF = 7;
    // tick codes, reset values, counter limits and countdown states
    localparam logic [1:0] TICK_4096 = 2'h0;
    localparam logic [1:0] TICK_64 = 2'h1;
    localparam logic [1:0] TICK_1 = 2'h2;
    localparam logic [1:0] TICK_MIN = 2'h3;
    localparam logic [4:0] DATE_RESET = 5'h01;
    localparam logic [5:0] SEC_MAX = 6'h3b;
    localparam logic [4:0] HOUR_MAX = 5'h17;
    localparam logic [4:0] DATE_MAX = 5'h1f;
    typedef enum logic [1:0] {
        RTUI_CD_IDLE = 2'b00,
        RTUI_CD_DELAY = 2'b01,
        RTUI_CD_COUNT = 2'b11
    } rtui_cd_state_t;
endpackage : rtui_pkg
`default_nettype wire

// File: verif/rtui_host_model.sv
// host side model of the shared interrupt line
`timescale 1ns/1ps
`default_nettype none
module rtui_host_model (
    // open drain pin of the device
    input wire logic irq_n_out,
    input wire logic irq_n_oe,
    // level seen by the host
    output logic irq_line
);
    // board pull-up holds the released line high
    assign irq_line = irq_n_oe ? irq_n_out : 1'b1;
endmodule : rtui_host_model
`default_nettype wire

// File: verif/rtui_irq_properties.sv
// port properties of the rtc interrupt block
`timescale 1ns/1ps
`default_nettype none
module rtui_irq_props #(
    parameter int unsigned UPD_HOLD_SEC_CYC = 20,
    parameter int unsigned CD_HOLD_SLOW_CYC = 5
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register port
    input wire logic [4:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // pins
    input wire logic ext_event_pin,
    input wire logic irq_n_out,
    input wire logic irq_n_oe,
    input wire logic update_pulse,
    input wire logic alarm_pulse,
    input wire logic clk_out_req
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    int unsigned upd_run;
    int unsigned cd_run;
    wire logic st_wr = reg_wr && reg_addr == rtui_pkg::REG_STATUS;
    wire logic c2_wr = reg_wr && reg_addr == rtui_pkg::REG_CTRL2;
    wire logic cd_only = irq_n_oe && !update_pulse && !alarm_pulse;
    // lengths of the current low phases
    always_ff @(posedge ref_clk) begin
        upd_run <= (rst || !update_pulse) ? 0 : upd_run + 1;
        cd_run <= (rst || !cd_only) ? 0 : cd_run + 1;
    end
    chk_drain_only: assert property (irq_n_oe |-> irq_n_out == 1'b0)
        else $error("interrupt pin driven high");
    chk_preset_nibble: assert property ($past(reg_rd) && $past(reg_addr) == rtui_pkg::REG_PRESET_HI
        |-> reg_rdata[7:4] == 4'h0)
        else $error("preset high read has extra bits");
    chk_upd_pin: assert property (update_pulse |-> irq_n_oe)
        else $error("update pulse without low pin");
    chk_alarm_pin: assert property (alarm_pulse |-> ##[0:1] irq_n_oe)
        else $error("alarm pulse without low pin");
    chk_upd_hold: assert property (update_pulse |-> upd_run < UPD_HOLD_SEC_CYC)
        else $error("update low held too long");
    chk_cd_hold: assert property (cd_only |-> cd_run < CD_HOLD_SLOW_CYC)
        else $error("countdown low held too long");
    chk_upd_flag_clr: assert property (st_wr && !reg_wdata[rtui_pkg::ST_UPDATE] && update_pulse
        |-> ##[1:2] !update_pulse)
        else $error("update low kept after flag clear");
    chk_alarm_en_clr: assert property (c2_wr && !reg_wdata[rtui_pkg::C2_ALM_IE]
        |-> ##[1:2] !alarm_pulse)
        else $error("alarm signal kept after enable clear");
    chk_gate_cause: assert property (clk_out_req |-> update_pulse || alarm_pulse
        || $past(update_pulse) || $past(alarm_pulse))
        else $error("clock request without a source");
endmodule : rtui_irq_props
`default_nettype wire

// File: verif/rtui_irq_core_tb.sv
// self-checking bench of the rtc interrupt block
`timescale 1ns/1ps
`default_nettype none
module rtui_irq_core_tb;
    localparam int unsigned TICK = 4;
    localparam int SEC = TICK * 4096;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] reg_addr = 5'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic ext_event_pin = 1'b0;
    logic [7:0] reg_rdata;
    logic irq_n_out;
    logic irq_n_oe;
    logic update_pulse;
    logic alarm_pulse;
    logic clk_out_req;
    logic irq_line;
    int errors = 0;
    int compares = 0;
    int low_cyc = 0;
    int n;
    int h;
    wire logic [2:0] ev = {alarm_pulse, update_pulse, irq_n_oe};
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (irq_line === 1'b0) low_cyc++;
    rtui_irq_core #(.TICK_CYC(TICK), .START_DLY_CYC(2), .CD_HOLD_FAST_CYC(3), .CD_HOLD_SLOW_CYC(5),
        .UPD_HOLD_SEC_CYC(20), .UPD_HOLD_MIN_CYC(7)) u_rtui_irq_core (
        .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_event_pin(ext_event_pin), .irq_n_out(irq_n_out),
        .irq_n_oe(irq_n_oe), .update_pulse(update_pulse), .alarm_pulse(alarm_pulse), .clk_out_req(clk_out_req));
    rtui_host_model u_rtui_host_model (.irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe), .irq_line(irq_line));
    task automatic give_verdict();
        $display("counts: %0d compares, %0d errors", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rdc(input logic [4:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        check({8'h00, reg_rdata}, {8'h00, exp});
    endtask : rdc
    task automatic wait_lvl(input int b, input logic v, input int lim);
        n = 0;
        #1;
        while (ev[b] !== v) begin
            @(posedge ref_clk);
            #1;
            n++;
            if (n > lim) begin
                errors++;
                $display("mismatch at %0t: wait ran out", $time);
                give_verdict();
            end
        end
    endtask : wait_lvl
    task automatic quiet_for(input int cyc);
        h = low_cyc;
        repeat (cyc) @(posedge ref_clk);
        check(16'(low_cyc - h), 16'h0000);
    endtask : quiet_for
    task automatic t_countdown(input logic [1:0] code, input logic [7:0] pre, input int hold, input int tc);
        int lo;
        lo = pre * tc + (code == rtui_pkg::TICK_4096 ? 2 : 0);
        wr(rtui_pkg::REG_PRESET_LO, pre);
        wr(rtui_pkg::REG_CTRL2, 8'h01);
        wr(rtui_pkg::REG_CTRL1, {6'h01, code});
        wait_lvl(0, 1'b1, lo + tc + 8);
        check({15'h0000, n >= lo && n <= lo + tc + 4}, 16'h0001);
        wait_lvl(0, 1'b0, 20);
        check(16'(n), 16'(hold));
        h = n;
        wait_lvl(0, 1'b1, lo + tc);
        check(16'(n + h), 16'(pre * tc));
        rdc(rtui_pkg::REG_PRESET_LO, pre);
        rdc(rtui_pkg::REG_PRESET_HI, 8'h00);
        wr(rtui_pkg::REG_CTRL1, 8'h00);
        rdc(rtui_pkg::REG_STATUS, 8'h01);
        wr(rtui_pkg::REG_STATUS, 8'h06);
        rdc(rtui_pkg::REG_STATUS, 8'h00);
        $display("countdown code %0d done", code);
    endtask : t_countdown
    task automatic t_update();
        wr(rtui_pkg::REG_PRESET_LO, 8'h00);
        wr(rtui_pkg::REG_CTRL1, 8'h04);
        quiet_for(60);
        wr(rtui_pkg::REG_CTRL1, 8'h00);
        wr(rtui_pkg::REG_CTRL2, 8'h00);
        wr(rtui_pkg::REG_SECONDS, 8'h00);
        quiet_for(SEC + 50);
        rdc(rtui_pkg::REG_STATUS, 8'h00);
        wr(rtui_pkg::REG_CTRL2, 8'h2a);
        @(posedge ref_clk);
        ext_event_pin <= 1'b1;
        @(posedge ref_clk);
        ext_event_pin <= 1'b0;
        wait_lvl(1, 1'b1, SEC + 20);
        check({15'h0000, n >= SEC - 8 && n <= SEC + 8}, 16'h0001);
        @(posedge ref_clk);
        #1;
        check({15'h0000, clk_out_req}, 16'h0001);
        check({15'h0000, irq_line}, 16'h0000);
        rdc(rtui_pkg::REG_STATUS, 8'h02);
        wr(rtui_pkg::REG_STATUS, 8'h05);
        wait_lvl(1, 1'b0, 3);
        $display("update second done");
    endtask : t_update
    task automatic t_minute();
        wr(rtui_pkg::REG_ALM_MIN, 8'h01);
        wr(rtui_pkg::REG_DATE, 8'h00);
        wr(rtui_pkg::REG_CTRL2, 8'h06);
        wr(rtui_pkg::REG_CTRL1, 8'h10);
        wr(rtui_pkg::REG_SECONDS, 8'h3b);
        wait_lvl(1, 1'b1, SEC + 20);
        check({15'h0000, n >= SEC - 8}, 16'h0001);
        wait_lvl(1, 1'b0, 20);
        check(16'(n), 16'h0007);
        rdc(rtui_pkg::REG_STATUS, 8'h02);
        wr(rtui_pkg::REG_STATUS, 8'h00);
        $display("update minute done");
    endtask : t_minute
    task automatic t_alarm();
        wr(rtui_pkg::REG_ALM_MIN, 8'h80);
        wr(rtui_pkg::REG_ALM_HOUR, 8'h80);
        wr(rtui_pkg::REG_ALM_DATE, 8'h80);
        wr(rtui_pkg::REG_CTRL2, 8'h14);
        wr(rtui_pkg::REG_CTRL1, 8'h00);
        wr(rtui_pkg::REG_SECONDS, 8'h3b);
        wait_lvl(2, 1'b1, SEC + 20);
        repeat (2) @(posedge ref_clk);
        #1;
        check({15'h0000, irq_line}, 16'h0000);
        check({15'h0000, clk_out_req}, 16'h0001);
        rdc(rtui_pkg::REG_STATUS, 8'h04);
        wr(rtui_pkg::REG_CTRL2, 8'h10);
        wait_lvl(2, 1'b0, 3);
        wr(rtui_pkg::REG_CTRL2, 8'h14);
        wait_lvl(2, 1'b1, 3);
        wr(rtui_pkg::REG_STATUS, 8'h00);
        wait_lvl(2, 1'b0, 3);
        rdc(rtui_pkg::REG_STATUS, 8'h00);
        $display("alarm done");
    endtask : t_alarm
    task automatic t_stop();
        wr(rtui_pkg::REG_CTRL2, 8'h06);
        wr(rtui_pkg::REG_CTRL1, 8'h80);
        wr(rtui_pkg::REG_SECONDS, 8'h3b);
        quiet_for(SEC + 50);
        rdc(rtui_pkg::REG_STATUS, 8'h00);
        $display("stop done");
    endtask : t_stop
    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        rdc(rtui_pkg::REG_STATUS, 8'h00);
        rdc(5'h1f, 8'h00);
        // alarm enable stays off while the byte is storage
        wr(rtui_pkg::REG_ALM_MIN, 8'h2a);
        rdc(rtui_pkg::REG_ALM_MIN, 8'h2a);
        t_countdown(rtui_pkg::TICK_4096, 8'h03, 3, TICK);
        t_countdown(rtui_pkg::TICK_64, 8'h01, 5, TICK * 64);
        t_update();
        t_minute();
        t_alarm();
        t_stop();
        give_verdict();
    end
endmodule : rtui_irq_core_tb
bind rtui_irq_core rtui_irq_props #(.UPD_HOLD_SEC_CYC(UPD_HOLD_SEC_CYC), .CD_HOLD_SLOW_CYC(CD_HOLD_SLOW_CYC))
    u_rtui_irq_props (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_event_pin(ext_event_pin), .irq_n_out(irq_n_out),
    .irq_n_oe(irq_n_oe), .update_pulse(update_pulse), .alarm_pulse(alarm_pulse), .clk_out_req(clk_out_req));
`default_nettype wire
